// [sim/pcl_host_model.sv]
// Host model that drives the configuration request, clock and data pins.
`timescale 1ns/1ps
`default_nettype none
module pcl_host_model (
  input wire logic clk,
  input wire logic status_wire,
  output logic request_n,
  output logic config_clock,
  output logic user_startup_clock,
  output logic [pcl_pkg::DATA_W-1:0] config_data
);
  initial begin
    request_n = 1'b1;
    config_clock = 1'b0;
    user_startup_clock = 1'b0;
    config_data = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse_request(input int low_cyc);
    cyc(1);
    request_n <= 1'b0;
    cyc(low_cyc);
    request_n <= 1'b1;
  endtask
  // Waits out both lead times before the first clock rise of a frame.
  task automatic start_frame();
    int n;
    n = 0;
    cyc(25000);
    while (!status_wire && n < 30000) begin
      n++;
      cyc(1);
    end
    cyc(500);
  endtask
  // Data goes stale once its hold time has run out, so it is inverted then.
  // One byte every 160 ns keeps the throughput far below the ceiling.
  task automatic send_byte(input logic [7:0] b);
    config_data <= b;
    cyc(2);
    config_clock <= 1'b1;
    cyc(20);
    config_clock <= 1'b0;
    config_data <= ~b;
    cyc(18);
  endtask
  // Three trailing cycles let the device digest the last byte before the clock stops.
  task automatic trail_clocks();
    repeat (3) begin
      config_clock <= 1'b1;
      cyc(20);
      config_clock <= 1'b0;
      cyc(20);
    end
  endtask
  task automatic run_user_clock(input int n);
    cyc(1);
    repeat (n) begin
      user_startup_clock <= 1'b1;
      cyc(20);
      user_startup_clock <= 1'b0;
      cyc(20);
    end
  endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the configuration load sequencer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic user_clock_option = 1'b0;
  logic auto_restart = 1'b0;
  logic load_error = 1'b0;
  logic load_complete = 1'b0;
  wire request_n;
  wire config_clock;
  wire user_startup_clock;
  wire [7:0] config_data;
  wire status_wire;
  wire done_wire;
  logic status_out, status_oe, done_out, done_oe, byte_valid;
  logic user_clock_enable, data_release, user_mode;
  logic [7:0] byte_data;
  int fail_count = 0;
  int samples_checked = 0;
  logic [7:0] pat [4] = '{8'h00, 8'ha5, 8'hff, 8'h3c};
  int oe_run = 0;
  int oe_width = 0;
  always #2 clk = ~clk;
  // Width of the last finished status pulse, in core clock cycles.
  always @(negedge clk) begin
    if (status_oe === 1'b1) begin
      oe_run <= oe_run + 1;
    end else begin
      if (oe_run != 0) begin
        oe_width <= oe_run;
      end
      oe_run <= 0;
    end
  end
  // Both lines are open drain with pull-ups; only the device pulls them here.
  assign status_wire = status_oe ? status_out : 1'b1;
  assign done_wire = done_oe ? done_out : 1'b1;
  pcl_sequencer #(.POR_CYC(20), .CD2UM_CYC(30)) uut (
    .clk(clk), .reset(reset), .clk_en(clk_en), .request_n(request_n),
    .config_clock(config_clock), .user_startup_clock(user_startup_clock),
    .config_data(config_data), .user_clock_option(user_clock_option),
    .auto_restart(auto_restart), .status_in(status_wire), .status_out(status_out),
    .status_oe(status_oe), .done_in(done_wire), .done_out(done_out), .done_oe(done_oe),
    .load_error(load_error), .load_complete(load_complete), .byte_data(byte_data),
    .byte_valid(byte_valid), .user_clock_enable(user_clock_enable),
    .data_release(data_release), .user_mode(user_mode)
  );
  pcl_host_model host (
    .clk(clk), .status_wire(status_wire), .request_n(request_n),
    .config_clock(config_clock), .user_startup_clock(user_startup_clock),
    .config_data(config_data)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Outputs are read at the falling edge so that the rising edge has settled.
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic scen_request(input logic from_user);
    int n;
    if (from_user) begin
      check("status_oe user", status_oe, 8'h00);
      check("done_oe user", done_oe, 8'h00);
    end
    fork
      host.pulse_request(500);
      begin
        tick(200);
        check("status_oe pulled", status_oe, 8'h01);
        check("done_oe pulled", done_oe, 8'h01);
        check("user_mode left", user_mode, 8'h00);
      end
    join
    n = 0;
    while (status_oe !== 1'b0 && n < 30000) begin
      n++;
      tick(1);
    end
    check("status release", n <= 25000, 8'h01);
    tick(1);
    check("status width", oe_width >= pcl_pkg::STATUS_MIN_CYC, 8'h01);
    check("status width max", oe_width <= pcl_pkg::STATUS_MAX_CYC, 8'h01);
    host.start_frame();
  endtask
  task automatic send_bytes();
    int n;
    for (int i = 0; i < 4; i++) begin
      fork
        host.send_byte(pat[i]);
        begin
          n = 0;
          while (byte_valid !== 1'b1 && n < 30) begin
            n++;
            tick(1);
          end
          check("byte_data", byte_data, pat[i]);
          tick(1);
          check("byte_valid pulse", byte_valid, 8'h00);
        end
      join
    end
    host.trail_clocks();
    check("byte trail", byte_data, ~pat[3]);
    check("done_oe loading", done_oe, 8'h01);
  endtask
  task automatic complete_load();
    int n;
    @(posedge clk);
    load_complete <= 1'b1;
    n = 0;
    while (done_oe !== 1'b0 && n < 10) begin
      n++;
      tick(1);
    end
    @(posedge clk);
    load_complete <= 1'b0;
  endtask
  task automatic scen_finish_osc();
    int n;
    complete_load();
    // A low clock enable freezes the startup wait, so it must end as much later.
    clk_en <= 1'b0;
    host.cyc(50);
    clk_en <= 1'b1;
    n = 0;
    while (user_mode !== 1'b1 && n < 200) begin
      n++;
      tick(1);
    end
    check("user mode delay", n >= 30 && n <= 40, 8'h01);
    check("data_release", data_release, 8'h01);
    check("status_oe user", status_oe, 8'h00);
  endtask
  task automatic scen_error();
    int n;
    @(posedge clk);
    load_error <= 1'b1;
    @(posedge clk);
    load_error <= 1'b0;
    tick(4);
    check("status_oe error", status_oe, 8'h01);
    check("done_oe error", done_oe, 8'h01);
    n = 0;
    while (status_oe !== 1'b0 && n < 3000) begin
      n++;
      tick(1);
    end
    check("auto restart", n >= 2490 && n < 2600, 8'h01);
    tick(1);
    check("error width", oe_width >= pcl_pkg::STATUS_MIN_CYC, 8'h01);
    host.cyc(500);
  endtask
  task automatic scen_finish_usr();
    int n;
    complete_load();
    n = 0;
    while (user_clock_enable !== 1'b1 && n < 100) begin
      n++;
      tick(1);
    end
    check("user clock enable delay", n >= 10 && n < 100, 8'h01);
    host.run_user_clock(298);
    tick(10);
    check("user_mode early", user_mode, 8'h00);
    host.run_user_clock(1);
    tick(2);
    check("user_mode on time", user_mode, 8'h01);
    check("data_release", data_release, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    tick(5);
    check("status_oe por", status_oe, 8'h01);
    check("done_oe por", done_oe, 8'h01);
    check("status_out", status_out, 8'h00);
    check("done_out", done_out, 8'h00);
    tick(30);
    scen_request(1'b0);
    send_bytes();
    scen_finish_osc();
    @(posedge clk);
    user_clock_option <= 1'b1;
    auto_restart <= 1'b1;
    scen_request(1'b1);
    send_bytes();
    scen_error();
    send_bytes();
    scen_finish_usr();
    stop_test();
  end
  // About 72000 cycles are expected; the limit stops a hang near 95000.
  initial begin
    #380000;
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire

// [verilog/pcl_pkg.sv]
// Constants, pin carrier and state type for the parallel configuration load sequencer.
`default_nettype none
package pcl_pkg;

  // Core clock.
  localparam int unsigned CLK_PERIOD_NS = 4;

  // Request low to completion low and to status low, longest time.
  localparam int unsigned CF2CD_MAX_NS = 800;
  localparam int unsigned CF2CD_MAX_CYC = CF2CD_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned CF2ST0_MAX_NS = 800;
  localparam int unsigned CF2ST0_MAX_CYC = CF2ST0_MAX_NS / CLK_PERIOD_NS;

  // Status low pulse width, least and longest.
  localparam int unsigned STATUS_MIN_NS = 10000;
  localparam int unsigned STATUS_MIN_CYC = (STATUS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STATUS_MAX_NS = 100000;
  localparam int unsigned STATUS_MAX_CYC = STATUS_MAX_NS / CLK_PERIOD_NS;

  // Completion high to user mode on the internal oscillator, least and longest time.
  localparam int unsigned CD2UM_MIN_NS = 20000;
  localparam int unsigned CD2UM_MIN_CYC = (CD2UM_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CD2UM_MAX_NS = 100000;

  // Completion high to user startup clock enable: four longest clock periods.
  localparam int unsigned CFG_CLK_PERIOD_NS = 10;
  localparam int unsigned CD2CU_PERIODS = 4;
  localparam int unsigned CD2CU_NS = CD2CU_PERIODS * CFG_CLK_PERIOD_NS;
  localparam int unsigned CD2CU_CYC = (CD2CU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // User startup clock periods from enable to user mode.
  localparam int unsigned USR_START_PERIODS = 299;

  // Power-on reset delay.
  localparam int unsigned POR_NS = 12000000;
  localparam int unsigned POR_CYC = POR_NS / CLK_PERIOD_NS;

  localparam int unsigned TIMER_W = 24;
  localparam int unsigned EDGE_W = 9;
  localparam int unsigned DATA_W = 8;

  // Pins from outside the core clock domain, synchronised as one group.
  typedef struct packed {
    logic request_n;
    logic config_clock;
    logic user_startup_clock;
    logic status_in;
    logic done_in;
    logic user_clock_option;
    logic auto_restart;
    logic [DATA_W-1:0] data;
  } pcl_pins_s;

  typedef enum logic [2:0] {
    ST_POR,
    ST_RESET,
    ST_WAIT_HI,
    ST_LOAD,
    ST_ERROR,
    ST_INIT,
    ST_START,
    ST_USER
  } pcl_state_e;

endpackage
`default_nettype wire

// [verilog/pcl_sequencer.sv]
// Device side of the passive byte-wide configuration load sequence.
//
// Behaviour
// RL1: In user mode status and completion stay high; request falling starts reconfiguration.
// RL2: Completion line pulled low within 800 ns of request going low.
// RL3: Status line pulled low within 800 ns of request going low.
// RL4: Host holds request low at least 2 us.
// RL5: Each status low pulse lasts 10 to 100 us unless host extends it.
// RL6: Status released within 100 us after request returns high.
// RL7: Host waits 100 us after request high before first clock rise.
// RL8: Host waits 2 us after status high before first clock rise.
// RL9: Status low through power-on delay; completion low before and during load.
// RL10: Oscillator startup enters user mode 20 to 100 us after completion high.
// RL11: User startup clock enabled no sooner than four clock periods after completion.
// RL12: User mode follows 299 user startup clock periods after enable.
// RL13: Host drives the configuration clock after load, never floating.
// RL14: After load the eight data pins are released to user I/O.
// RL15: With decompression, host pauses clock low and presents data before restart.
// RL16: With decompression, host keeps data throughput at most 200 Mbps.
// RL17: One full byte captured on every configuration clock rising edge.
// RL18: A load error pulls status low and resets the sequence internally.
// RL19: With decompression, host stops clock only three cycles after last byte.
`timescale 1ns/1ps
`default_nettype none
module pcl_sequencer #(
  parameter int unsigned POR_CYC = pcl_pkg::POR_CYC,
  parameter int unsigned CD2UM_CYC = pcl_pkg::CD2UM_MIN_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic request_n,
  input wire logic config_clock,
  input wire logic user_startup_clock,
  input wire logic [pcl_pkg::DATA_W-1:0] config_data,
  input wire logic user_clock_option,
  input wire logic auto_restart,
  input wire logic status_in,
  output logic status_out,
  output logic status_oe,
  input wire logic done_in,
  output logic done_out,
  output logic done_oe,
  input wire logic load_error,
  input wire logic load_complete,
  output logic [pcl_pkg::DATA_W-1:0] byte_data,
  output logic byte_valid,
  output logic user_clock_enable,
  output logic data_release,
  output logic user_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  pcl_pkg::pcl_pins_s pins_in;
  pcl_pkg::pcl_pins_s sync1_q;
  pcl_pkg::pcl_pins_s sync2_q;
  pcl_pkg::pcl_pins_s prev_q;

  always_comb begin
    pins_in = '{
      request_n: request_n,
      config_clock: config_clock,
      user_startup_clock: user_startup_clock,
      status_in: status_in,
      done_in: done_in,
      user_clock_option: user_clock_option,
      auto_restart: auto_restart,
      data: config_data
    };
  end

  // Only the second stage and its delayed copy feed any logic.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else if (clk_en) begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  logic req_s;
  logic status_s;
  logic done_s;
  logic opt_s;
  logic cclk_rise;
  logic uclk_rise;

  assign req_s = sync2_q.request_n;
  assign status_s = sync2_q.status_in;
  assign done_s = sync2_q.done_in;
  assign opt_s = sync2_q.user_clock_option;
  assign cclk_rise = sync2_q.config_clock && !prev_q.config_clock;
  assign uclk_rise = sync2_q.user_startup_clock && !prev_q.user_startup_clock;

  function automatic logic reached(input logic [pcl_pkg::TIMER_W-1:0] t,
                                   input int unsigned lim);
    reached = (32'(t) + 32'd1 >= lim);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing.

  pcl_pkg::pcl_state_e state_q;
  logic [pcl_pkg::TIMER_W-1:0] timer_q;
  logic [pcl_pkg::EDGE_W-1:0] uedge_q;
  logic uclk_en_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= pcl_pkg::ST_POR;
      timer_q <= '0;
      uedge_q <= '0;
    end else if (clk_en) begin
      if (timer_q != '1) begin
        timer_q <= timer_q + 1'b1;
      end
      if (state_q != pcl_pkg::ST_POR && state_q != pcl_pkg::ST_RESET && !req_s) begin
        state_q <= pcl_pkg::ST_RESET; // RL1
        timer_q <= '0;
      end else begin
        unique case (state_q)
          pcl_pkg::ST_POR: begin
            if (reached(timer_q, POR_CYC)) begin // RL9
              state_q <= pcl_pkg::ST_RESET;
              timer_q <= '0;
            end
          end
          pcl_pkg::ST_RESET: begin
            // The pulse is timed from its start, so a long request low extends it.
            if (req_s && reached(timer_q, pcl_pkg::STATUS_MIN_CYC)) begin // RL5 RL6
              state_q <= pcl_pkg::ST_WAIT_HI;
            end
          end
          pcl_pkg::ST_WAIT_HI: begin
            // The host may hold the shared status line low to delay the load.
            if (status_s) begin
              state_q <= pcl_pkg::ST_LOAD;
            end
          end
          pcl_pkg::ST_LOAD: begin
            if (load_error) begin
              state_q <= pcl_pkg::ST_ERROR; // RL18
              timer_q <= '0;
            end else if (load_complete) begin
              state_q <= pcl_pkg::ST_INIT;
            end
          end
          pcl_pkg::ST_ERROR: begin
            if (sync2_q.auto_restart && reached(timer_q, pcl_pkg::STATUS_MIN_CYC)) begin // RL18
              state_q <= pcl_pkg::ST_WAIT_HI;
            end
          end
          pcl_pkg::ST_INIT: begin
            // Startup is timed from the completion line actually reading high.
            timer_q <= '0;
            uedge_q <= '0;
            if (done_s) begin
              state_q <= pcl_pkg::ST_START;
            end
          end
          pcl_pkg::ST_START: begin
            if (!opt_s) begin
              if (reached(timer_q, CD2UM_CYC)) begin // RL10
                state_q <= pcl_pkg::ST_USER;
              end
            end else if (uclk_en_q && uclk_rise) begin
              if (32'(uedge_q) + 32'd1 >= pcl_pkg::USR_START_PERIODS) begin // RL12
                state_q <= pcl_pkg::ST_USER;
              end else begin
                uedge_q <= uedge_q + 1'b1;
              end
            end
          end
          pcl_pkg::ST_USER: begin
            state_q <= pcl_pkg::ST_USER;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      uclk_en_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q != pcl_pkg::ST_START || !opt_s) begin
        uclk_en_q <= 1'b0;
      end else if (reached(timer_q, pcl_pkg::CD2CU_CYC)) begin
        uclk_en_q <= 1'b1; // RL11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte capture.

  logic [pcl_pkg::DATA_W-1:0] byte_q;
  logic byte_valid_q;

  // Data and clock share the same synchroniser depth, so the byte seen with
  // the rising edge is the one the host set up before that edge.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      byte_q <= '0;
      byte_valid_q <= 1'b0;
    end else if (clk_en) begin
      byte_valid_q <= 1'b0;
      if (state_q == pcl_pkg::ST_LOAD && cclk_rise && status_s) begin
        byte_q <= sync2_q.data; // RL17
        byte_valid_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drives.

  logic status_oe_q;
  logic done_oe_q;
  logic user_mode_q;
  logic release_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_oe_q <= 1'b1;
      done_oe_q <= 1'b1;
      user_mode_q <= 1'b0;
      release_q <= 1'b0;
    end else if (clk_en) begin
      status_oe_q <= (state_q == pcl_pkg::ST_POR) || (state_q == pcl_pkg::ST_RESET) ||
                     (state_q == pcl_pkg::ST_ERROR); // RL3 RL9 RL18
      done_oe_q <= !((state_q == pcl_pkg::ST_INIT) || (state_q == pcl_pkg::ST_START) ||
                     (state_q == pcl_pkg::ST_USER)); // RL2 RL9
      user_mode_q <= (state_q == pcl_pkg::ST_USER); // RL1
      release_q <= (state_q == pcl_pkg::ST_USER); // RL14
    end
  end

  assign status_out = 1'b0;
  assign done_out = 1'b0;
  assign status_oe = status_oe_q;
  assign done_oe = done_oe_q;
  assign user_mode = user_mode_q;
  assign data_release = release_q;
  assign user_clock_enable = uclk_en_q;
  assign byte_data = byte_q;
  assign byte_valid = byte_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic [pcl_pkg::TIMER_W-1:0] ast_low_q;
  logic [pcl_pkg::TIMER_W-1:0] ast_rel_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ast_low_q <= '0;
      ast_rel_q <= '0;
    end else if (clk_en) begin
      ast_low_q <= status_oe_q ? ast_low_q + 1'b1 : '0;
      ast_rel_q <= (status_oe_q && req_s && state_q == pcl_pkg::ST_RESET) ? ast_rel_q + 1'b1 : '0;
    end
  end

  AST_DONE_LOW: assert property (@(posedge clk) disable iff (reset || !clk_en) // RL2
    $fell(req_s) |-> ##[1:200] done_oe_q)
    else $error("completion line not pulled low after request fell");

  AST_STATUS_LOW: assert property (@(posedge clk) disable iff (reset || !clk_en) // RL3
    $fell(req_s) |-> ##[1:200] status_oe_q)
    else $error("status line not pulled low after request fell");

  AST_STATUS_MIN: assert property (@(posedge clk) disable iff (reset || !clk_en) // RL5
    $fell(status_oe_q) |-> 32'($past(ast_low_q)) + 32'd1 >= pcl_pkg::STATUS_MIN_CYC)
    else $error("status low pulse shorter than its least width");

  AST_STATUS_REL: assert property (@(posedge clk) disable iff (reset || !clk_en) // RL6
    32'(ast_rel_q) <= pcl_pkg::STATUS_MAX_CYC)
    else $error("status line held past its release limit");

  AST_USER_HIGH: assert property (@(posedge clk) disable iff (reset || !clk_en) // RL1
    (user_mode_q && req_s) |-> (!status_oe_q && !done_oe_q))
    else $error("status or completion driven in user mode");

  AST_POR_HOLD: assert property (@(posedge clk) disable iff (reset || !clk_en) // RL9
    (state_q == pcl_pkg::ST_POR) |=> (status_oe_q && done_oe_q))
    else $error("lines not held low during power-on delay");

  AST_BYTE: assert property (@(posedge clk) disable iff (reset || !clk_en) // RL17
    (state_q == pcl_pkg::ST_LOAD && cclk_rise && status_s && req_s)
      |=> (byte_valid_q && byte_q == $past(sync2_q.data)))
    else $error("byte not captured on clock rise");

  AST_ERROR: assert property (@(posedge clk) disable iff (reset || !clk_en) // RL18
    (state_q == pcl_pkg::ST_LOAD && load_error && req_s) |-> ##2 status_oe_q)
    else $error("status not pulled low after load error");

  AST_UCLK_EN: assert property (@(posedge clk) disable iff (reset || !clk_en) // RL11
    $rose(uclk_en_q) |-> 32'($past(timer_q)) + 32'd1 >= pcl_pkg::CD2CU_CYC)
    else $error("user startup clock enabled too early");

  AST_OSC_START: assert property (@(posedge clk) disable iff (reset || !clk_en) // RL10
    ($rose(user_mode_q) && !opt_s) |-> (32'($past(timer_q, 2)) + 32'd1 >= CD2UM_CYC) &&
      (32'($past(timer_q, 2)) * pcl_pkg::CLK_PERIOD_NS <= pcl_pkg::CD2UM_MAX_NS))
    else $error("user mode entered outside its window after completion");

  AST_UCLK_COUNT: assert property (@(posedge clk) disable iff (reset || !clk_en) // RL12
    ($rose(user_mode_q) && opt_s) |-> 32'(uedge_q) + 32'd1 == pcl_pkg::USR_START_PERIODS)
    else $error("user mode not after the counted startup clock periods");

  AST_RELEASE: assert property (@(posedge clk) disable iff (reset || !clk_en) // RL14
    data_release |-> (!done_oe_q && !status_oe_q))
    else $error("data pins released before configuration completed");

endmodule
`default_nettype wire

// [verilog/unused_placeholder_removed.sv]
// Intentionally empty design unit list; all logic lives in pcl_sequencer.
`default_nettype none
`default_nettype wire
